/* File: core/hsp_strap_pins.sv */
// strap capture, serial pin steering and status pin muxing
//
// Summary of operation
// - A low port 4 over-current pin means an over-current event, high none.
// - The serial mode strap is sampled at reset release, 1 i2c, 0 smbus.
// - In i2c mode the block drives serial clock and data as eeprom master.
// - In smbus mode the block is a target and the host drives the clock.
// - After reset, if enabled, the mode pin shows upstream ss suspend.
// - The power management strap is sampled, 0 enables power switching.
// - In smbus mode target address bit 1 comes from the power strap.
// - After reset, if enabled, the power strap pin shows ss connection.
// - The polarity strap sets power control outputs low or high active.
// - Under power management four per-port outputs control port power.
// - Each power control pin is sampled as that port's charging strap.
// - The ganged strap selects individual (0) or ganged (1) control.
`timescale 1ns/1ns
module hsp_strap_pins
  import hsp_pkg::*;
(
  input  wire logic                 i_mclk,             // 100 MHz clock
  input  wire logic                 i_srst,             // sync reset, high
  // strap / status pins
  input  wire logic                 i_serial_mode_select_n, // mode pin in
  output logic                      o_serial_mode_select_n, // mode pin out
  output logic                      o_serial_mode_select_oe, // drive en
  input  wire logic                 i_power_switching_disable_n, // pin in
  output logic                      o_power_switching_disable_n, // pin out
  output logic                      o_power_switching_disable_oe, // en
  input  wire logic                 i_power_control_polarity, // strap pin
  input  wire logic                 i_ganged_strap,     // ganged strap pin
  // port power control / charging strap pins
  input  wire logic [hsp_pkg::NUM_PORTS-1:0] i_port_power_control, // in
  output logic [hsp_pkg::NUM_PORTS-1:0] o_port_power_control, // out
  output logic [hsp_pkg::NUM_PORTS-1:0] o_port_power_control_oe, // en
  input  wire logic                 i_port4_overcurrent_n, // oc pin, low
  // serial pins, open drain
  input  wire logic                 i_scl,              // clock pin level
  output logic                      o_scl,              // clock drive value
  output logic                      o_scl_oe,           // pull clock low
  input  wire logic                 i_sda,              // data pin level
  output logic                      o_sda,              // data drive value
  output logic                      o_sda_oe,           // pull data low
  // internal side
  input  wire logic                 i_ctl_scl_low,      // controller pulls scl
  input  wire logic                 i_ctl_sda_low,      // controller pulls sda
  input  wire logic                 i_tgt_sda_low,      // target pulls sda
  output logic                      o_scl_sync,         // synced scl level
  output logic                      o_sda_sync,         // synced sda level
  input  wire logic [hsp_pkg::NUM_PORTS-1:0] i_port_power_on, // power req
  input  wire logic                 i_ss_suspend,       // upstream suspended
  input  wire logic                 i_ss_connected,     // upstream ss link
  input  wire logic                 i_ss_suspend_out_en, // feature bit
  input  wire logic                 i_ss_connect_out_en, // feature bit
  output hsp_pkg::hsp_straps_t      o_straps,           // latched straps
  output logic                      o_i2c_mode,         // i2c controller
  output logic                      o_smbus_mode,       // smbus target
  output logic                      o_target_address_bit1, // smbus addr
  output logic                      o_power_switch_en,  // switching on
  output logic                      o_port4_overcurrent, // oc event, high
  output logic                      o_straps_valid      // straps latched
);
  import hsp_pkg::*;

  localparam int NSYNC = 2 * NUM_PORTS + 7;

  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_s;
  logic             s_mode;
  logic             s_pwr;
  logic             s_pol;
  logic             s_gang;
  logic             s_oc4;
  logic             s_scl;
  logic             s_sda;
  logic [NUM_PORTS-1:0] s_ppc;

  assign pins_raw = {i_port_power_control, i_serial_mode_select_n,
                     i_power_switching_disable_n, i_power_control_polarity,
                     i_ganged_strap, i_port4_overcurrent_n, i_scl, i_sda,
                     {NUM_PORTS{1'b0}}};

  hsp_sync #(.W(NSYNC)) u_sync (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_pin  (pins_raw),
    .o_sync (pins_s)
  );

  assign s_ppc  = pins_s[NSYNC-1 -: NUM_PORTS];
  assign s_mode = pins_s[NUM_PORTS+6];
  assign s_pwr  = pins_s[NUM_PORTS+5];
  assign s_pol  = pins_s[NUM_PORTS+4];
  assign s_gang = pins_s[NUM_PORTS+3];
  assign s_oc4  = pins_s[NUM_PORTS+2];
  assign s_scl  = pins_s[NUM_PORTS+1];
  assign s_sda  = pins_s[NUM_PORTS];

  // wait out the synchroniser before sampling, so straps are the
  // levels present at release, not the reset value of the flops
  logic [1:0]  wait_q;
  logic [1:0]  wait_d;
  hsp_state_t  state_q;
  hsp_state_t  state_d;
  hsp_straps_t straps_q;
  hsp_straps_t straps_d;

  always_comb begin
    state_d  = state_q;
    wait_d   = wait_q;
    straps_d = straps_q;
    unique case (state_q)
      ST_RESET: begin
        wait_d = wait_q + 2'(1);
        if (wait_q == 2'(SYNC_STAGES - 1)) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        straps_d.serial_mode    = s_mode;
        straps_d.pwr_sw_disable = s_pwr;
        straps_d.pwr_pol_high   = s_pol;
        straps_d.ganged         = s_gang;
        straps_d.charging_en    = s_ppc;
        state_d                 = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q  <= ST_RESET;
      wait_q   <= 2'h0;
      straps_q <= STRAPS_RESET;
    end else begin
      state_q  <= state_d;
      wait_q   <= wait_d;
      straps_q <= straps_d;
    end
  end

  logic running;
  logic i2c_mode;
  logic pwr_en;
  assign running  = (state_q == ST_RUN);
  assign i2c_mode = (straps_q.serial_mode == MODE_I2C);
  assign pwr_en   = running && !straps_q.pwr_sw_disable;

  // output register group: data outputs come from flops
  logic [NUM_PORTS-1:0] ppc_d;
  logic [NUM_PORTS-1:0] ppc_q;
  logic                 mode_pin_d;
  logic                 mode_pin_q;
  logic                 pwr_pin_d;
  logic                 pwr_pin_q;
  logic                 oc4_d;
  logic                 oc4_q;
  logic                 ppc_oe_d;
  logic                 ppc_oe_q;

  always_comb begin
    logic [NUM_PORTS-1:0] on;
    on = PORTS_OFF;
    if (pwr_en) begin
      // ganged: any requested port powers all of them
      on = straps_q.ganged ? {NUM_PORTS{|i_port_power_on}}
                           : i_port_power_on;
    end
    ppc_d = straps_q.pwr_pol_high ? on : ~on;
    mode_pin_d = i_ss_suspend;
    pwr_pin_d  = i_ss_connected;
    // over-current inputs ignored when switching is disabled
    oc4_d = pwr_en && (s_oc4 == OC_ASSERTED);
    // enable one edge late, once ppc_q holds the latched polarity
    ppc_oe_d = pwr_en;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ppc_q      <= PORTS_OFF;
      mode_pin_q <= 1'b0;
      pwr_pin_q  <= 1'b0;
      oc4_q      <= 1'b0;
      ppc_oe_q   <= 1'b0;
    end else begin
      ppc_q      <= ppc_d;
      mode_pin_q <= mode_pin_d;
      pwr_pin_q  <= pwr_pin_d;
      oc4_q      <= oc4_d;
      ppc_oe_q   <= ppc_oe_d;
    end
  end

  // power control pins are charging straps until sampled, so hold off
  assign o_port_power_control    = ppc_q;
  // driving at the latch edge would show the reset-polarity level,
  // which turns every port on for a cycle when active low
  assign o_port_power_control_oe = {NUM_PORTS{ppc_oe_q}};
  assign o_serial_mode_select_n  = mode_pin_q;
  assign o_serial_mode_select_oe = running && i_ss_suspend_out_en;
  assign o_power_switching_disable_n  = pwr_pin_q;
  assign o_power_switching_disable_oe = running && i_ss_connect_out_en;

  // open drain: drive low only; smbus host owns scl
  assign o_scl    = 1'b0;
  assign o_sda    = 1'b0;
  assign o_scl_oe = running && i2c_mode && i_ctl_scl_low;
  assign o_sda_oe = running && (i2c_mode ? i_ctl_sda_low
                                         : i_tgt_sda_low);
  assign o_scl_sync = s_scl;
  assign o_sda_sync = s_sda;

  assign o_straps              = straps_q;
  assign o_i2c_mode            = running && i2c_mode;
  assign o_smbus_mode          = running && !i2c_mode;
  // address bit follows the latched strap, not the later status output
  assign o_target_address_bit1 = straps_q.pwr_sw_disable;
  assign o_power_switch_en     = pwr_en;
  assign o_port4_overcurrent   = oc4_q;
  assign o_straps_valid        = running;
endmodule : hsp_strap_pins

/* File: shared/hsp_pkg.sv */
// package for the hub strap and status pin block
package hsp_pkg;
  localparam int NUM_PORTS = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic MODE_I2C = 1'b1;
  localparam logic MODE_SMBUS = 1'b0;
  localparam logic POL_ACTIVE_HIGH = 1'b1;
  localparam logic OC_ASSERTED = 1'b0;
  localparam int ADDR_BIT1_POS = 1;
  localparam logic [NUM_PORTS-1:0] PORTS_OFF = 4'h0;

  typedef struct packed {
    logic                 serial_mode;      // 1 i2c, 0 smbus
    logic                 pwr_sw_disable;   // 1 power switching off
    logic                 pwr_pol_high;     // 1 active high
    logic                 ganged;           // 1 ganged control
    logic [NUM_PORTS-1:0] charging_en;      // per-port charging support
  } hsp_straps_t;

  localparam hsp_straps_t STRAPS_RESET = '{
    serial_mode:    1'b1,
    pwr_sw_disable: 1'b0,
    pwr_pol_high:   1'b1,
    ganged:         1'b0,
    charging_en:    4'h0
  };

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b11
  } hsp_state_t;
endpackage : hsp_pkg

/* File: core/hsp_sync.sv */
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module hsp_sync #(
  parameter int W = 1
) (
  input  wire logic         i_mclk,  // hub clock
  input  wire logic         i_srst,  // sync reset, high
  input  wire logic [W-1:0] i_pin,   // async pin levels
  output logic      [W-1:0] o_sync   // synchronised levels
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
  end

  // reset value only; pins are re-captured two edges later anyway
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule : hsp_sync

/* File: bench/hsp_partner.sv */
// behavioural far side: power switch and serial bus lines
`timescale 1ns/1ns
module hsp_partner (
  input  wire logic i_mclk,    // hub clock
  input  wire logic i_scl_oe,  // block pulls clock low
  input  wire logic i_sda_oe,  // block pulls data low
  input  wire logic i_host_en, // smbus host clocks the bus
  input  wire logic i_fault,   // switch reports over-current
  output logic      o_scl,     // resolved clock line
  output logic      o_sda,     // resolved data line
  output logic      o_oc_n     // switch fault flag
);
  logic [1:0] div_q = 2'h0;
  always @(posedge i_mclk) div_q <= i_host_en ? div_q + 2'h1 : 2'h0;
  // pull-ups win unless a party pulls low
  assign o_scl = !(i_scl_oe || (i_host_en && div_q[1]));
  assign o_sda = !i_sda_oe;
  assign o_oc_n = !i_fault;
endmodule : hsp_partner

/* File: bench/hsp_checker.sv */
// assertions on the strap and status pin block ports
`timescale 1ns/1ns
module hsp_checker
  import hsp_pkg::*;
(
  input wire logic                 i_mclk,
  input wire logic                 i_srst,
  input wire logic                 i_port4_overcurrent_n,
  input wire logic                 i_ctl_scl_low,
  input wire logic [NUM_PORTS-1:0] i_port_power_on,
  input wire logic                 i_ss_suspend_out_en,
  input wire logic                 o_serial_mode_select_oe,
  input wire logic [NUM_PORTS-1:0] o_port_power_control,
  input wire logic                 o_scl_oe,
  input wire hsp_straps_t          o_straps,
  input wire logic                 o_i2c_mode,
  input wire logic                 o_smbus_mode,
  input wire logic                 o_target_address_bit1,
  input wire logic                 o_power_switch_en,
  input wire logic                 o_port4_overcurrent,
  input wire logic                 o_straps_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_valid; $fell(i_srst) |-> ##[1:4] o_straps_valid; endproperty
  a_valid: assert property (p_valid) else $error("straps late");
  property p_hold;
    o_straps_valid && $past(o_straps_valid) |-> $stable(o_straps);
  endproperty
  a_hold: assert property (p_hold) else $error("straps moved");
  property p_scl_tgt; o_smbus_mode |-> !o_scl_oe; endproperty
  a_scl_tgt: assert property (p_scl_tgt) else $error("scl driven");
  property p_scl_ctl; o_i2c_mode && i_ctl_scl_low |-> o_scl_oe; endproperty
  a_scl_ctl: assert property (p_scl_ctl) else $error("scl idle");
  property p_ss_oe;
    o_serial_mode_select_oe == (o_straps_valid && i_ss_suspend_out_en);
  endproperty
  a_ss_oe: assert property (p_ss_oe) else $error("mode pin oe");
  property p_pwr;
    o_straps_valid |-> o_power_switch_en == !o_straps.pwr_sw_disable;
  endproperty
  a_pwr: assert property (p_pwr) else $error("switch enable");
  property p_addr;
    o_straps_valid |-> o_target_address_bit1 == o_straps.pwr_sw_disable;
  endproperty
  a_addr: assert property (p_addr) else $error("address bit");
  property p_oc;
    o_power_switch_en && $fell(i_port4_overcurrent_n)
      |-> ##[2:3] o_port4_overcurrent;
  endproperty
  a_oc: assert property (p_oc) else $error("oc missed");
  property p_ppc;
    o_power_switch_en && $past(o_power_switch_en) && !o_straps.ganged
      |-> o_port_power_control ==
          ($past(i_port_power_on) ^ {NUM_PORTS{!o_straps.pwr_pol_high}});
  endproperty
  a_ppc: assert property (p_ppc) else $error("power level");
endmodule : hsp_checker

/* File: bench/tb.sv */
// testbench for the strap and status pin block
`timescale 1ns/1ns
module tb;
  import hsp_pkg::*;
  logic i_mclk = 0, i_srst = 1, fault = 0, i_ctl_scl_low = 0;
  logic i_ctl_sda_low = 0, i_tgt_sda_low = 0, i_ss_suspend = 0;
  logic i_ss_connected = 0, i_ss_suspend_out_en = 0, i_ss_connect_out_en = 0;
  logic i_serial_mode_select_n, i_power_switching_disable_n, i_scl, i_sda;
  logic i_power_control_polarity, i_ganged_strap, i_port4_overcurrent_n;
  logic o_serial_mode_select_n, o_serial_mode_select_oe, o_scl, o_scl_oe;
  logic o_power_switching_disable_n, o_power_switching_disable_oe, o_sda;
  logic o_sda_oe, o_scl_sync, o_sda_sync, o_i2c_mode, o_smbus_mode;
  logic o_target_address_bit1, o_power_switch_en, o_port4_overcurrent;
  logic o_straps_valid;
  wire [1:0] mode_pin = {o_serial_mode_select_oe, o_serial_mode_select_n};
  wire [1:0] link_pin = {o_power_switching_disable_oe,
                         o_power_switching_disable_n};
  logic [NUM_PORTS-1:0] i_port_power_control, i_port_power_on = 4'h0;
  logic [NUM_PORTS-1:0] o_port_power_control, o_port_power_control_oe;
  hsp_straps_t o_straps, strap = 8'h00;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  // straps, then power levels for request 3, then power oe
  logic [15:0] rows [4] = '{16'hA53F, 16'h0ACF, 16'h6000, 16'h900F};
  // two-way pins: block output while enabled, else strap resistor
  assign i_serial_mode_select_n =
    o_serial_mode_select_oe ? o_serial_mode_select_n : strap.serial_mode;
  assign i_power_switching_disable_n = o_power_switching_disable_oe ?
    o_power_switching_disable_n : strap.pwr_sw_disable;
  assign i_port_power_control = (o_port_power_control_oe &
    o_port_power_control) | (~o_port_power_control_oe & strap.charging_en);
  assign i_power_control_polarity = strap.pwr_pol_high;
  assign i_ganged_strap = strap.ganged;
  hsp_strap_pins DUT (
    .i_mclk                      (i_mclk),
    .i_srst                      (i_srst),
    .i_serial_mode_select_n      (i_serial_mode_select_n),
    .o_serial_mode_select_n      (o_serial_mode_select_n),
    .o_serial_mode_select_oe     (o_serial_mode_select_oe),
    .i_power_switching_disable_n (i_power_switching_disable_n),
    .o_power_switching_disable_n (o_power_switching_disable_n),
    .o_power_switching_disable_oe(o_power_switching_disable_oe),
    .i_power_control_polarity    (i_power_control_polarity),
    .i_ganged_strap              (i_ganged_strap),
    .i_port_power_control        (i_port_power_control),
    .o_port_power_control        (o_port_power_control),
    .o_port_power_control_oe     (o_port_power_control_oe),
    .i_port4_overcurrent_n       (i_port4_overcurrent_n),
    .i_scl                       (i_scl),
    .o_scl                       (o_scl),
    .o_scl_oe                    (o_scl_oe),
    .i_sda                       (i_sda),
    .o_sda                       (o_sda),
    .o_sda_oe                    (o_sda_oe),
    .i_ctl_scl_low               (i_ctl_scl_low),
    .i_ctl_sda_low               (i_ctl_sda_low),
    .i_tgt_sda_low               (i_tgt_sda_low),
    .o_scl_sync                  (o_scl_sync),
    .o_sda_sync                  (o_sda_sync),
    .i_port_power_on             (i_port_power_on),
    .i_ss_suspend                (i_ss_suspend),
    .i_ss_connected              (i_ss_connected),
    .i_ss_suspend_out_en         (i_ss_suspend_out_en),
    .i_ss_connect_out_en         (i_ss_connect_out_en),
    .o_straps                    (o_straps),
    .o_i2c_mode                  (o_i2c_mode),
    .o_smbus_mode                (o_smbus_mode),
    .o_target_address_bit1       (o_target_address_bit1),
    .o_power_switch_en           (o_power_switch_en),
    .o_port4_overcurrent         (o_port4_overcurrent),
    .o_straps_valid              (o_straps_valid)
  );
  hsp_partner u_far (.i_mclk(i_mclk), .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
    .i_host_en(o_smbus_mode), .i_fault(fault), .o_scl(i_scl),
    .o_sda(i_sda), .o_oc_n(i_port4_overcurrent_n));
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (++cyc > 3000) begin
    n_mismatch++;
    test_done();
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task set_status(input logic v);
    i_ss_suspend_out_en = v;
    i_ss_connect_out_en = v;
    i_ss_suspend = v;
    i_ss_connected = v;
    i_ctl_scl_low = v;
    i_ctl_sda_low = v;
    i_tgt_sda_low = 1'b0;
    i_port_power_on = v ? 4'h3 : 4'h0;
  endtask : set_status
  initial begin
    @(negedge i_mclk);
    for (int r = 0; r < 4; r++) begin
      strap = rows[r][15:8];
      set_status(1'b0);
      i_srst = 1;
      repeat (12) @(negedge i_mclk);
      i_srst = 0;
      for (int k = 0; k < 8 && o_straps_valid !== 1'b1; k++)
        @(negedge i_mclk);
      chk(o_straps, strap);
      chk({o_i2c_mode, o_smbus_mode}, {strap[7], !strap[7]});
      chk(o_target_address_bit1, strap.pwr_sw_disable);
      chk(o_power_switch_en, !strap.pwr_sw_disable);
      set_status(1'b1);
      repeat (3) @(negedge i_mclk);
      chk(o_port_power_control_oe, rows[r][3:0]);
      if (rows[r][0]) chk(o_port_power_control, rows[r][7:4]);
      chk(o_scl_oe, strap.serial_mode);
      if (strap.serial_mode) chk(o_scl_sync, 1'b0);
      chk({o_scl, o_sda}, 8'h00);
      chk(o_sda_oe, strap.serial_mode);
      chk(o_sda_sync, !strap.serial_mode);
      chk(mode_pin, 8'h03);
      chk(link_pin, 8'h03);
      {i_ctl_sda_low, i_tgt_sda_low, i_ss_suspend} = 3'b010;
      @(negedge i_mclk);
      chk(o_sda_oe, !strap.serial_mode);
      chk(mode_pin, 8'h02);
      chk(link_pin, 8'h03);
      strap = ~strap;
      set_status(1'b0);
      repeat (4) @(negedge i_mclk);
      chk(o_straps, ~strap);
      $display("row %0d done", r);
    end
    fault = 1;
    repeat (5) @(negedge i_mclk);
    chk(o_port4_overcurrent, 1'b1);
    fault = 0;
    repeat (5) @(negedge i_mclk);
    chk(o_port4_overcurrent, 1'b0);
    $display("over-current done");
    i_srst = 1;
    repeat (2) @(negedge i_mclk);
    chk(o_straps, STRAPS_RESET);
    chk(o_straps_valid, 1'b0);
    $display("reset done");
    test_done();
  end
endmodule : tb
bind hsp_strap_pins hsp_checker u_chk (
  .i_mclk                 (i_mclk),
  .i_srst                 (i_srst),
  .i_port4_overcurrent_n  (i_port4_overcurrent_n),
  .i_ctl_scl_low          (i_ctl_scl_low),
  .i_port_power_on        (i_port_power_on),
  .i_ss_suspend_out_en    (i_ss_suspend_out_en),
  .o_serial_mode_select_oe(o_serial_mode_select_oe),
  .o_port_power_control   (o_port_power_control),
  .o_scl_oe               (o_scl_oe),
  .o_straps               (o_straps),
  .o_i2c_mode             (o_i2c_mode),
  .o_smbus_mode           (o_smbus_mode),
  .o_target_address_bit1  (o_target_address_bit1),
  .o_power_switch_en      (o_power_switch_en),
  .o_port4_overcurrent    (o_port4_overcurrent),
  .o_straps_valid         (o_straps_valid)
);
